/* tec_defs.svh */
// register map, field positions and timing constants of the entropy collector
`ifndef TEC_DEFS_SVH
`define TEC_DEFS_SVH
`define TEC_OFF_WORD0 12'h000
`define TEC_OFF_WORD1 12'h004
`define TEC_OFF_WORD2 12'h008
`define TEC_OFF_WORD3 12'h00c
`define TEC_OFF_STATUS 12'h010
`define TEC_OFF_MASK 12'h014
`define TEC_OFF_CONFIG 12'h018
`define TEC_OFF_CONTROL 12'h01c
`define TEC_OFF_EVT_STAT 12'h020
`define TEC_OFF_EVT_EN 12'h024
`define TEC_OFF_EVT_CLR 12'h028
`define TEC_OFF_ID4 12'hfd0
`define TEC_OFF_ID0 12'hfe0
`define TEC_OFF_ID1 12'hfe4
`define TEC_OFF_ID2 12'hfe8
`define TEC_OFF_ID3 12'hfec
`define TEC_OFF_CID0 12'hff0
`define TEC_OFF_CID1 12'hff4
`define TEC_OFF_CID2 12'hff8
`define TEC_OFF_CID3 12'hffc
`define TEC_CID0_VAL 32'h0000000d
`define TEC_CID1_VAL 32'h000000f0
`define TEC_CID2_VAL 32'h00000005
`define TEC_CID3_VAL 32'h000000b1
`define TEC_BIT_READY 0
`define TEC_BIT_START 0
`define TEC_BIT_ABORT 1
`define TEC_EVT_READY 0
`define TEC_EVT_ABORT 1
`define TEC_RESP_OKAY 2'b00
`define TEC_RESP_SLVERR 2'b10
// last capture count: 128 kept bits plus two that flush the synchroniser
`define TEC_CAP_LAST 8'h81
`endif

/* tec_pkg.sv */
// types shared by the entropy collector files
package tec_pkg;
    // run sequencer states, gray coded along idle-pulse-capture-done
    typedef enum logic [1:0] {
        TEC_IDLE = 2'b00,
        TEC_PULSE = 2'b01,
        TEC_CAPTURE = 2'b11,
        TEC_DONE = 2'b10
    } tec_state_t;
    // one register write decoded for the core
    typedef struct packed {
        logic start;
        logic abort;
        logic ack;
        logic cfg_we;
        logic [31:0] cfg_data;
    } tec_cmd_t;
endpackage

/* tec_sequencer.sv */
// run sequencer: enable pulse timing and 128-bit capture
`timescale 1ns/100ps
`include "tec_defs.svh"
module tec_sequencer
    import tec_pkg::*;
#(
    parameter int WORDS = 4
) (
    // clock and reset
    input wire logic clk,
    input wire logic resetn,
    // commands
    input wire tec_cmd_t cmd,
    // entropy source, already synchronised
    input wire logic src_bit,
    // results
    output logic src_enable,
    output logic busy,
    output logic ready,
    output logic done_pulse,
    output logic [WORDS*32-1:0] result,
    output logic [31:0] cfg_value
);
    tec_state_t state_r, state_nxt;
    logic [31:0] cnt_r;
    logic [31:0] cfg_r;
    logic [7:0] cap_r;
    logic [WORDS*32-1:0] shift_r;
    logic en_r;
    logic rdy_r;
    logic done_r;
    logic [WORDS*32-1:0] res_r;

    // pulse end: count of zero or one both give one cycle
    wire pulse_last = (cnt_r <= 32'h00000001);
    // two extra shifts push out bits that crossed the synchroniser before the source saw the enable
    wire cap_last = (cap_r == `TEC_CAP_LAST);
    wire kill = cmd.abort;

    // next state
    always_comb begin
        state_nxt = state_r;
        unique case (state_r)
            TEC_IDLE: if (cmd.start) state_nxt = TEC_PULSE;
            TEC_PULSE: if (pulse_last) state_nxt = TEC_CAPTURE;
            TEC_CAPTURE: if (cap_last) state_nxt = TEC_DONE;
            TEC_DONE: state_nxt = TEC_IDLE;
        endcase
        if (kill) state_nxt = TEC_IDLE;
    end

    // state and counters
    always_ff @(posedge clk) begin
        if (!resetn) begin
            state_r <= TEC_IDLE;
            cnt_r <= 32'h0;
            cap_r <= 8'h00;
            en_r <= 1'b0;
            shift_r <= '0;
        end else begin
            state_r <= state_nxt;
            en_r <= (state_nxt == TEC_PULSE);
            if (state_r == TEC_IDLE) cnt_r <= cfg_r;
            else if (state_r == TEC_PULSE) cnt_r <= cnt_r - 32'h1;
            cap_r <= (state_r == TEC_CAPTURE) ? cap_r + 8'h01 : 8'h00;
            if (state_r == TEC_CAPTURE) shift_r <= {shift_r[WORDS*32-2:0], src_bit};
        end
    end

    // sample count held here, written only while the enable pulse is not running
    always_ff @(posedge clk) begin
        if (!resetn) cfg_r <= 32'h0;
        else if (cmd.cfg_we && state_r != TEC_PULSE && !cmd.start) cfg_r <= cmd.cfg_data;
    end

    // result and ready: capture lands in the same cycle that ready rises; a fresh result wins over an ack
    always_ff @(posedge clk) begin
        if (!resetn) begin
            res_r <= '0;
            rdy_r <= 1'b0;
            done_r <= 1'b0;
        end else begin
            done_r <= (state_r == TEC_CAPTURE) && cap_last && !kill;
            if (kill) begin
                res_r <= '0;
                rdy_r <= 1'b0;
            end else if (state_r == TEC_DONE) begin
                res_r <= shift_r;
                rdy_r <= 1'b1;
            end else if (cmd.ack) begin
                res_r <= '0;
                rdy_r <= 1'b0;
            end
        end
    end

    assign src_enable = en_r;
    assign busy = (state_r != TEC_IDLE);
    assign ready = rdy_r;
    assign done_pulse = done_r;
    assign result = res_r;
    assign cfg_value = cfg_r;
endmodule

/* tec_top.sv */
// trusted entropy collector with AXI4-Lite register slave
`timescale 1ns/100ps
`include "tec_defs.svh"
module tec_top
    import tec_pkg::*;
#(
    parameter logic [31:0] ID4_VAL = 32'h00000011, // arbitrary identity value
    parameter logic [31:0] ID0_VAL = 32'h00000022, // arbitrary identity value
    parameter logic [31:0] ID1_VAL = 32'h00000033, // arbitrary identity value
    parameter logic [31:0] ID2_VAL = 32'h00000044, // arbitrary identity value
    parameter logic [31:0] ID3_VAL = 32'h00000000
) (
    // clock and reset
    input wire logic clk,
    input wire logic resetn,
    // axi4-lite write address
    input wire logic [11:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    // axi4-lite write data
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    // axi4-lite write response
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    // axi4-lite read address
    input wire logic [11:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    // axi4-lite read data
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // entropy source
    input wire logic src_bit_pin,
    output logic src_enable,
    // interrupt
    output logic irq
);
    ////////////////////////////////////////////////////////////////////////////////
    // declarations
    logic aw_held_r, w_held_r;
    logic [11:0] aw_addr_r;
    logic [31:0] w_data_r;
    logic [3:0] w_strb_r;
    logic bvalid_r, rvalid_r;
    logic [1:0] bresp_r, rresp_r;
    logic [31:0] rdata_r;
    logic [31:0] rd_val;
    logic rd_hit;
    logic mask_r;
    logic [1:0] evt_stat_r, evt_en_r;
    logic irq_r;
    logic [31:0] cfg_value;
    logic sync1_r, sync2_r;
    logic busy, ready, done_pulse, seq_enable;
    logic [127:0] result;
    tec_cmd_t cmd;

    // register index match on a byte address
    function automatic logic hit(input logic [11:0] a, input logic [11:0] off);
        hit = (a[11:2] == off[11:2]);
    endfunction

    ////////////////////////////////////////////////////////////////////////////////
    // source bit crosses in through two flops
    always_ff @(posedge clk) begin
        if (!resetn) begin
            sync1_r <= 1'b0;
            sync2_r <= 1'b0;
        end else begin
            sync1_r <= src_bit_pin;
            sync2_r <= sync1_r;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // write channels: address and data taken in either order
    wire wr_go = aw_held_r && w_held_r && !bvalid_r;
    wire full_low = w_strb_r[0];
    wire wr_status = wr_go && hit(aw_addr_r, `TEC_OFF_STATUS);
    wire wr_mask = wr_go && hit(aw_addr_r, `TEC_OFF_MASK);
    wire wr_config = wr_go && hit(aw_addr_r, `TEC_OFF_CONFIG);
    wire wr_control = wr_go && hit(aw_addr_r, `TEC_OFF_CONTROL);
    wire wr_evt_en = wr_go && hit(aw_addr_r, `TEC_OFF_EVT_EN);
    wire wr_evt_clr = wr_go && hit(aw_addr_r, `TEC_OFF_EVT_CLR);
    wire wr_known = wr_status | wr_mask | wr_config | wr_control | wr_evt_en | wr_evt_clr;

    // decoded commands; reserved control bits are dropped
    assign cmd.start = wr_control && full_low && w_data_r[`TEC_BIT_START] && !busy;
    assign cmd.abort = wr_control && full_low && w_data_r[`TEC_BIT_ABORT];
    assign cmd.ack = wr_status && full_low && w_data_r[`TEC_BIT_READY];
    assign cmd.cfg_we = wr_config && (&w_strb_r) && !seq_enable;
    assign cmd.cfg_data = w_data_r;

    always_ff @(posedge clk) begin
        if (!resetn) begin
            aw_held_r <= 1'b0;
            w_held_r <= 1'b0;
            aw_addr_r <= 12'h000;
            w_data_r <= 32'h0;
            w_strb_r <= 4'h0;
            bvalid_r <= 1'b0;
            bresp_r <= `TEC_RESP_OKAY;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                aw_held_r <= 1'b1;
                aw_addr_r <= s_axi_awaddr;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_held_r <= 1'b1;
                w_data_r <= s_axi_wdata;
                w_strb_r <= s_axi_wstrb;
            end
            if (wr_go) begin
                aw_held_r <= 1'b0;
                w_held_r <= 1'b0;
                bvalid_r <= 1'b1;
                bresp_r <= wr_known ? `TEC_RESP_OKAY : `TEC_RESP_SLVERR;
            end else if (bvalid_r && s_axi_bready) begin
                bvalid_r <= 1'b0;
            end
        end
    end

    assign s_axi_awready = !aw_held_r && !bvalid_r;
    assign s_axi_wready = !w_held_r && !bvalid_r;
    assign s_axi_bvalid = bvalid_r;
    assign s_axi_bresp = bresp_r;

    ////////////////////////////////////////////////////////////////////////////////
    // read channel: one-cycle decode into a held answer
    always_comb begin
        rd_val = 32'h0;
        rd_hit = 1'b1;
        if (hit(s_axi_araddr, `TEC_OFF_WORD0)) rd_val = result[31:0];
        else if (hit(s_axi_araddr, `TEC_OFF_WORD1)) rd_val = result[63:32];
        else if (hit(s_axi_araddr, `TEC_OFF_WORD2)) rd_val = result[95:64];
        else if (hit(s_axi_araddr, `TEC_OFF_WORD3)) rd_val = result[127:96];
        else if (hit(s_axi_araddr, `TEC_OFF_STATUS)) rd_val = {31'h0, ready};
        else if (hit(s_axi_araddr, `TEC_OFF_MASK)) rd_val = {31'h0, mask_r};
        else if (hit(s_axi_araddr, `TEC_OFF_CONFIG)) rd_val = cfg_value;
        else if (hit(s_axi_araddr, `TEC_OFF_CONTROL)) rd_val = 32'h0;
        else if (hit(s_axi_araddr, `TEC_OFF_EVT_STAT)) rd_val = {30'h0, evt_stat_r};
        else if (hit(s_axi_araddr, `TEC_OFF_EVT_EN)) rd_val = {30'h0, evt_en_r};
        else if (hit(s_axi_araddr, `TEC_OFF_EVT_CLR)) rd_val = 32'h0;
        else if (hit(s_axi_araddr, `TEC_OFF_ID4)) rd_val = ID4_VAL;
        else if (hit(s_axi_araddr, `TEC_OFF_ID0)) rd_val = ID0_VAL;
        else if (hit(s_axi_araddr, `TEC_OFF_ID1)) rd_val = ID1_VAL;
        else if (hit(s_axi_araddr, `TEC_OFF_ID2)) rd_val = ID2_VAL;
        else if (hit(s_axi_araddr, `TEC_OFF_ID3)) rd_val = ID3_VAL;
        else if (hit(s_axi_araddr, `TEC_OFF_CID0)) rd_val = `TEC_CID0_VAL;
        else if (hit(s_axi_araddr, `TEC_OFF_CID1)) rd_val = `TEC_CID1_VAL;
        else if (hit(s_axi_araddr, `TEC_OFF_CID2)) rd_val = `TEC_CID2_VAL;
        else if (hit(s_axi_araddr, `TEC_OFF_CID3)) rd_val = `TEC_CID3_VAL;
        else rd_hit = 1'b0;
    end

    always_ff @(posedge clk) begin
        if (!resetn) begin
            rvalid_r <= 1'b0;
            rdata_r <= 32'h0;
            rresp_r <= `TEC_RESP_OKAY;
        end else if (s_axi_arvalid && s_axi_arready) begin
            rvalid_r <= 1'b1;
            rdata_r <= rd_val;
            rresp_r <= rd_hit ? `TEC_RESP_OKAY : `TEC_RESP_SLVERR;
        end else if (rvalid_r && s_axi_rready) begin
            rvalid_r <= 1'b0;
        end
    end

    assign s_axi_arready = !rvalid_r;
    assign s_axi_rvalid = rvalid_r;
    assign s_axi_rdata = rdata_r;
    assign s_axi_rresp = rresp_r;

    ////////////////////////////////////////////////////////////////////////////////
    // mask, event status and enable; a new event wins over its clear
    wire [1:0] evt_set = {cmd.abort, done_pulse};
    wire [1:0] evt_clr = wr_evt_clr ? w_data_r[1:0] : 2'b00;

    always_ff @(posedge clk) begin
        if (!resetn) begin
            mask_r <= 1'b0;
            evt_stat_r <= 2'b00;
            evt_en_r <= 2'b00;
        end else begin
            if (wr_mask && full_low) mask_r <= w_data_r[0];
            if (wr_evt_en && full_low) evt_en_r <= w_data_r[1:0];
            evt_stat_r <= (evt_stat_r & ~evt_clr) | evt_set;
        end
    end

    // interrupt: ready under its mask, or any enabled event
    always_ff @(posedge clk) begin
        if (!resetn) begin
            irq_r <= 1'b0;
        end else begin
            irq_r <= (mask_r && ready) || (|(evt_stat_r & evt_en_r));
        end
    end

    assign irq = irq_r;
    assign src_enable = seq_enable;

    ////////////////////////////////////////////////////////////////////////////////
    // run sequencer
    tec_sequencer #(
        .WORDS(4)
    ) u_seq (
        .clk(clk),
        .resetn(resetn),
        .cmd(cmd),
        .src_bit(sync2_r),
        .src_enable(seq_enable),
        .busy(busy),
        .ready(ready),
        .done_pulse(done_pulse),
        .result(result),
        .cfg_value(cfg_value)
    );
endmodule

/* tec_top_assertions.sv */
// port checks of the entropy collector
`timescale 1ns/100ps
`include "tec_defs.svh"
module tec_top_assertions
    import tec_pkg::*;
(
    // clock and reset
    input wire logic clk,
    input wire logic resetn,
    // register bus
    input wire logic [11:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    input wire logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic s_axi_wvalid,
    input wire logic s_axi_wready,
    input wire logic s_axi_bvalid,
    input wire logic [1:0] s_axi_rresp,
    input wire logic s_axi_rvalid,
    // source and interrupt
    input wire logic src_enable,
    input wire logic irq
);
    default clocking @(posedge clk);
    endclocking
    default disable iff (!resetn);
    ////////////////////////////////////////////////////////////////
    // decoded writes and shadows of what software set
    logic wr_hs;
    logic wctl;
    logic [31:0] cfg_r;
    logic [31:0] cnt_r;
    logic mask_r;
    logic evt_r;
    logic abort_r;
    assign wr_hs = s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
    assign wctl = wr_hs && s_axi_awaddr == `TEC_OFF_CONTROL;
    always_ff @(posedge clk) begin
        if (!resetn) begin
            cfg_r <= 32'h0;
            cnt_r <= 32'h0;
            mask_r <= 1'h0;
            evt_r <= 1'h0;
            abort_r <= 1'h0;
        end else begin
            cnt_r <= src_enable ? cnt_r + 32'h1 : 32'h0;
            if (wr_hs && s_axi_awaddr == `TEC_OFF_CONFIG && !src_enable) cfg_r <= s_axi_wdata;
            if (wr_hs && s_axi_awaddr == `TEC_OFF_MASK) mask_r <= s_axi_wdata[0];
            if (wr_hs && s_axi_awaddr == `TEC_OFF_EVT_EN) evt_r <= s_axi_wdata[0];
            if (wctl) abort_r <= s_axi_wdata[1];
        end
    end
    ////////////////////////////////////////////////////////////////
    a_reset_quiet: assert property ($rose(resetn) |-> !src_enable && !irq && !s_axi_bvalid && !s_axi_rvalid)
        else $error("outputs active after reset");
    a_start_enable: assert property (wctl && s_axi_wdata[1:0] == 2'h1 && !src_enable |-> ##[1:3] src_enable)
        else $error("start gave no enable");
    a_abort_drop: assert property (wctl && s_axi_wdata[1] |-> ##[1:3] !src_enable)
        else $error("abort left enable high");
    a_pulse_width: assert property ($fell(src_enable) && !abort_r |-> cnt_r == (cfg_r == 32'h0 ? 32'h1 : cfg_r))
        else $error("enable width wrong");
    a_zero_pulse: assert property ($rose(src_enable) && cfg_r == 32'h0 |=> !src_enable)
        else $error("zero count pulse too long");
    a_irq_gate: assert property ((!mask_r && !evt_r) [*3] |-> !irq)
        else $error("irq with nothing enabled");
    a_ack_clear: assert property (wr_hs && s_axi_awaddr == `TEC_OFF_STATUS && s_axi_wdata[0] && !evt_r |-> ##[1:3] !irq)
        else $error("ack left irq high");
    a_reserved_ctl: assert property (wctl && s_axi_wdata[1:0] == 2'h0 && !src_enable |=> !src_enable)
        else $error("reserved control bits acted");
    c_run: cover property ($rose(src_enable));
    c_irq: cover property ($rose(irq));
    c_slverr: cover property (s_axi_rvalid && s_axi_rresp == 2'h2);
endmodule
bind tec_top tec_top_assertions u_chk (
    .clk, .resetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wvalid,
    .s_axi_wready, .s_axi_bvalid, .s_axi_rresp, .s_axi_rvalid, .src_enable, .irq
);

/* tec_source_model.sv */
// entropy source model driven by the collector enable
`timescale 1ns/100ps
module tec_source_model (
    // clock
    input wire logic clk,
    // enable from the collector, level from the bench
    input wire logic enable,
    input wire logic level,
    // entropy bit
    output logic bit_o
);
    int hold_r = 0;
    // steady level while sampling and for a while after, garbage otherwise
    always @(posedge clk) begin
        hold_r <= enable ? 200 : (hold_r > 0 ? hold_r - 1 : 0);
        bit_o <= (enable || hold_r > 0) ? level : ~bit_o;
    end
    initial bit_o = 1'h0;
endmodule

/* tec_top_tb.sv */
// self-checking bench of the entropy collector
`timescale 1ns/100ps
`include "tec_defs.svh"
module tec_top_tb;
    logic clk = 1'h0;
    logic resetn = 1'h0;
    logic [11:0] s_axi_awaddr = 12'h0, s_axi_araddr = 12'h0;
    logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, rd_v;
    logic [3:0] s_axi_wstrb = 4'hf;
    logic s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0, s_axi_arvalid = 1'h0, s_axi_rready = 1'h0;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, src_bit_pin, src_enable, irq;
    logic [1:0] s_axi_bresp, s_axi_rresp, rr;
    logic level = 1'h1;
    int fails = 0, tests_run = 0, en_cnt = 0;
    tec_top dut (
        .clk, .resetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
        .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
        .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
        .src_bit_pin, .src_enable, .irq
    );
    tec_source_model u_src (.clk(clk), .enable(src_enable), .level(level), .bit_o(src_bit_pin));
    // clock and enable width monitor
    initial forever #25 clk = ~clk;
    always @(posedge clk) if (src_enable) en_cnt++;
    ////////////////////////////////////////////////////////////////
    task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
        tests_run++;
        if (seen !== exp) begin
            fails++;
            $display("unexpected %s expected %h seen %h", what, exp, seen);
        end
    endtask
    // bus write: address and data together, bready held until bvalid
    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        @(posedge clk);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'h1;
        s_axi_wvalid <= 1'h1;
        s_axi_bready <= 1'h1;
        do begin
            @(posedge clk);
            if (s_axi_awready) s_axi_awvalid <= 1'h0;
            if (s_axi_wready) s_axi_wvalid <= 1'h0;
        end while (!s_axi_bvalid);
        s_axi_bready <= 1'h0;
    endtask
    // bus read, result in rd_v and rr
    task automatic rd(input logic [11:0] a);
        @(posedge clk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'h1;
        s_axi_rready <= 1'h1;
        do begin
            @(posedge clk);
            if (s_axi_arready) s_axi_arvalid <= 1'h0;
        end while (!s_axi_rvalid);
        rd_v = s_axi_rdata;
        rr = s_axi_rresp;
        s_axi_rready <= 1'h0;
    endtask
    task automatic start(input logic [31:0] cfg, input logic lv);
        level <= lv;
        wr(`TEC_OFF_CONFIG, cfg);
        en_cnt = 0;
        wr(`TEC_OFF_CONTROL, 32'h1);
    endtask
    // wait for ready, then width and result words
    task automatic finish(input logic [31:0] cfg, input logic lv);
        int n = 0;
        do begin
            rd(`TEC_OFF_STATUS);
            n++;
        end while (rd_v[0] !== 1'h1 && n < 200);
        check(rd_v, 32'h1, "status");
        check(en_cnt, cfg == 32'h0 ? 32'h1 : cfg, "pulse");
        for (int i = 0; i < 4; i++) begin
            rd(12'(4 * i));
            check(rd_v, {32{lv}}, "word");
        end
    endtask
    task automatic ack();
        wr(`TEC_OFF_STATUS, 32'h1);
        rd(`TEC_OFF_STATUS);
        check(rd_v, 32'h0, "status");
        rd(`TEC_OFF_WORD0);
        check(rd_v, 32'h0, "word");
        check({31'h0, irq}, 32'h0, "irq");
    endtask
    ////////////////////////////////////////////////////////////////
    task automatic t_reset();
        logic [31:0] cid [4] = '{`TEC_CID0_VAL, `TEC_CID1_VAL, `TEC_CID2_VAL, `TEC_CID3_VAL};
        for (int i = 0; i < 7; i++) begin
            rd(12'(4 * i));
            check(rd_v, 32'h0, "reset value");
        end
        for (int i = 0; i < 4; i++) begin
            rd(12'(12'hff0 + 4 * i));
            check(rd_v, cid[i], "class word");
        end
        rd(12'h040);
        check({30'h0, rr}, 32'h2, "unmapped resp");
    endtask
    task automatic t_mask();
        wr(`TEC_OFF_MASK, 32'h1);
        start(32'h3, 1'h1);
        finish(32'h3, 1'h1);
        check({31'h0, irq}, 32'h1, "irq");
        ack();
        wr(`TEC_OFF_MASK, 32'h0);
        start(32'h0, 1'h1);
        finish(32'h0, 1'h1);
        check({31'h0, irq}, 32'h0, "irq");
        ack();
    endtask
    task automatic t_lock();
        start(32'h28, 1'h0);
        wr(`TEC_OFF_CONFIG, 32'h7);
        rd(`TEC_OFF_CONFIG);
        check(rd_v, 32'h28, "config");
        finish(32'h28, 1'h0);
        ack();
    endtask
    task automatic t_abort();
        // leave a result standing so that the abort has words to clear
        start(32'h2, 1'h1);
        finish(32'h2, 1'h1);
        start(32'h12c, 1'h0);
        repeat (5) @(posedge clk);
        wr(`TEC_OFF_CONTROL, 32'h2);
        repeat (3) @(posedge clk);
        check({31'h0, src_enable}, 32'h0, "enable");
        rd(`TEC_OFF_WORD3);
        check(rd_v, 32'h0, "word");
        wr(`TEC_OFF_CONTROL, 32'hfffffffc);
        repeat (4) @(posedge clk);
        check({31'h0, src_enable}, 32'h0, "enable");
        start(32'h2, 1'h0);
        finish(32'h2, 1'h0);
        ack();
    endtask
    task automatic t_events();
        wr(`TEC_OFF_EVT_EN, 32'h1);
        start(32'h1, 1'h1);
        finish(32'h1, 1'h1);
        check({31'h0, irq}, 32'h1, "event irq");
        wr(`TEC_OFF_EVT_CLR, 32'h1);
        repeat (3) @(posedge clk);
        check({31'h0, irq}, 32'h0, "event irq");
        wr(`TEC_OFF_EVT_EN, 32'h0);
        ack();
    endtask
    task automatic test_done();
        $display("checks %0d mismatches %0d", tests_run, fails);
        if (fails == 0 && tests_run > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////
    // reset, scenarios, verdict
    initial begin
        repeat (8) @(posedge clk);
        resetn <= 1'h1;
        t_reset();
        t_mask();
        t_lock();
        t_abort();
        t_events();
        test_done();
    end
    // watchdog far beyond the thousand or so cycles the scenarios need
    initial begin
        repeat (40000) @(posedge clk);
        fails++;
        test_done();
    end
endmodule
